// ==== hdl/host_port_cfg.svh ====
// constants of the host port data and address registers
// assumes inclusion by bare name from the design files
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH
`define HP_DATA_RST  32'h0000_0000
`define HP_ADDR_RST  32'h0000_0000
`define HP_HALF_ZERO 16'h0000
`define HP_HI_MSB    31
`define HP_HI_LSB    16
`define HP_LO_MSB    15
`define HP_LO_LSB    0
`define HP_SEL_DATA  1'b0
`define HP_SEL_ADDR  1'b1
`endif

// ==== hdl/host_port_pkg.sv ====
// types of the host port data and address registers
// assumes host_port_cfg.svh for the numeric constants
package host_port_pkg;
  typedef logic [31:0] word_t;
  typedef logic [15:0] half_t;
  typedef enum logic {
    RD_IDLE,
    RD_WAIT
  } rd_state_t;
endpackage

// ==== hdl/host_port_data_address_regs.sv ====
// host data port and the read/write address registers of the host port
// assumes host strobes already decoded to requests on sys_clk_i, held until host_ready_o
//
// Contract
// - one 32-bit data register between host and dma
// - host write fills word, then dma takes it
// - dma fills word first, then host reads it
// - 16-bit mode: two halfwords make one word
// - host reads/writes data; cpu has no access
// - multiplexed data goes through read and write fifos
// - separate read and write 32-bit address registers
// - single or dual address register configuration
// - host reads/writes addresses; cpu only reads
// - data and address registers reset to zero
// - halfword order picks which half comes first
`timescale 1ns/1ps
`include "host_port_cfg.svh"
module host_port_data_address_regs
  import host_port_pkg::*;
(
  input  wire logic  sys_clk_i,
  input  wire logic  rst_n_i,
  input  wire logic  ce_i,
  input  wire logic  mux16_i,
  input  wire logic  halfword_order_i,
  input  wire logic  dual_addr_i,
  input  wire logic  host_req_i,
  input  wire logic  host_rnw_i,
  input  wire logic  host_sel_i,
  input  wire logic  host_addr_sel_i,
  input  wire logic  host_second_i,
  input  wire word_t host_wdata_i,
  output word_t      host_rdata_o,
  output logic       host_ready_o,
  output logic       wr_valid_o,
  output word_t      wr_data_o,
  output word_t      wr_addr_o,
  input  wire logic  wr_ready_i,
  output logic       rd_req_o,
  output word_t      rd_addr_o,
  input  wire logic  rd_valid_i,
  input  wire word_t rd_data_i,
  output word_t      cpu_rd_addr_o,
  output word_t      cpu_wr_addr_o
);

  word_t     host_data_port;
  word_t     host_data_next;
  word_t     read_address_reg;
  word_t     read_address_next;
  word_t     write_address_reg;
  word_t     write_address_next;
  word_t     wf_data_reg;
  word_t     wf_data_next;
  word_t     wf_addr_reg;
  word_t     wf_addr_next;
  logic      wf_full_reg;
  logic      wf_full_next;
  word_t     rf_data_reg;
  word_t     rf_data_next;
  logic      rf_full_reg;
  logic      rf_full_next;
  rd_state_t rd_state_reg;
  rd_state_t rd_state_next;
  word_t     rdata_reg;
  word_t     rdata_next;
  logic      to_high;
  logic      word_done;
  logic      acc;
  logic      is_data;
  logic      is_addr;
  half_t     in_half;
  word_t     addr_src;
  word_t     addr_val;

  function automatic word_t merge(input word_t old, input half_t hw, input logic hi);
    merge = hi ? {hw, old[`HP_LO_MSB:`HP_LO_LSB]} : {old[`HP_HI_MSB:`HP_HI_LSB], hw};
  endfunction

  function automatic word_t pick(input word_t src, input logic m16, input logic hi);
    if (!m16) begin
      pick = src;
    end else if (hi) begin
      pick = {`HP_HALF_ZERO, src[`HP_HI_MSB:`HP_HI_LSB]};
    end else begin
      pick = {`HP_HALF_ZERO, src[`HP_LO_MSB:`HP_LO_LSB]};
    end
  endfunction

  assign in_half   = host_wdata_i[`HP_LO_MSB:`HP_LO_LSB];
  assign to_high   = ~host_second_i ^ halfword_order_i;
  assign word_done = ~mux16_i | host_second_i;
  assign is_data   = host_sel_i == `HP_SEL_DATA;
  assign is_addr   = host_sel_i == `HP_SEL_ADDR;
  assign addr_src  = (dual_addr_i && host_addr_sel_i) ? write_address_reg : read_address_reg;

  // a write stalls only on the word-completing half, so a first half never waits
  always_comb begin
    host_ready_o = 1'b1;
    if (host_req_i && is_data) begin
      if (!host_rnw_i) begin
        host_ready_o = ~(word_done & wf_full_reg);
      end else begin
        host_ready_o = rf_full_reg;
      end
    end
  end

  assign acc = ce_i & host_req_i & host_ready_o;

  always_comb begin
    host_data_next     = host_data_port;
    read_address_next  = read_address_reg;
    write_address_next = write_address_reg;
    wf_data_next       = wf_data_reg;
    wf_addr_next       = wf_addr_reg;
    wf_full_next       = wf_full_reg;
    rf_data_next       = rf_data_reg;
    rf_full_next       = rf_full_reg;
    rd_state_next      = rd_state_reg;
    rdata_next         = rdata_reg;
    addr_val           = mux16_i ? merge(addr_src, in_half, to_high) : host_wdata_i;
    if (wf_full_reg && wr_ready_i) begin
      wf_full_next = 1'b0;
    end
    case (rd_state_reg)
      RD_IDLE: begin
        if (host_req_i && is_data && host_rnw_i && !rf_full_reg) begin
          rd_state_next = RD_WAIT;
        end
      end
      RD_WAIT: begin
        if (rd_valid_i) begin
          rf_data_next  = rd_data_i;
          rf_full_next  = 1'b1;
          rd_state_next = RD_IDLE;
        end
      end
      default: begin
        rd_state_next = RD_IDLE;
      end
    endcase
    if (acc && is_data && !host_rnw_i) begin
      host_data_next = mux16_i ? merge(host_data_port, in_half, to_high) : host_wdata_i;
      if (word_done) begin
        wf_data_next = host_data_next;
        wf_addr_next = write_address_reg;
        wf_full_next = 1'b1;
      end
    end
    if (acc && is_data && host_rnw_i) begin
      host_data_next = rf_data_reg;
      rdata_next     = pick(rf_data_reg, mux16_i, to_high);
      if (word_done) begin
        rf_full_next = 1'b0;
      end
    end
    // the host owns these; values are taken as word addresses untouched
    if (acc && is_addr && !host_rnw_i) begin
      if (!dual_addr_i) begin
        read_address_next  = addr_val;
        write_address_next = addr_val;
      end else if (host_addr_sel_i) begin
        write_address_next = addr_val;
      end else begin
        read_address_next = addr_val;
      end
    end
    if (acc && is_addr && host_rnw_i) begin
      rdata_next = pick(addr_src, mux16_i, to_high);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_data_port    <= `HP_DATA_RST;
      read_address_reg  <= `HP_ADDR_RST;
      write_address_reg <= `HP_ADDR_RST;
      wf_data_reg       <= `HP_DATA_RST;
      wf_addr_reg       <= `HP_ADDR_RST;
      wf_full_reg       <= 1'b0;
      rf_data_reg       <= `HP_DATA_RST;
      rf_full_reg       <= 1'b0;
      rd_state_reg      <= RD_IDLE;
      rdata_reg         <= `HP_DATA_RST;
    end else if (ce_i) begin
      host_data_port    <= host_data_next;
      read_address_reg  <= read_address_next;
      write_address_reg <= write_address_next;
      wf_data_reg       <= wf_data_next;
      wf_addr_reg       <= wf_addr_next;
      wf_full_reg       <= wf_full_next;
      rf_data_reg       <= rf_data_next;
      rf_full_reg       <= rf_full_next;
      rd_state_reg      <= rd_state_next;
      rdata_reg         <= rdata_next;
    end
  end

  assign host_rdata_o  = rdata_reg;
  assign wr_valid_o    = wf_full_reg;
  assign wr_data_o     = wf_data_reg;
  assign wr_addr_o     = wf_addr_reg;
  assign rd_req_o      = rd_state_reg == RD_WAIT;
  assign rd_addr_o     = read_address_reg;
  // cpu gets a view only; there is no cpu path to the data register
  assign cpu_rd_addr_o = read_address_reg;
  assign cpu_wr_addr_o = write_address_reg;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_wr_word_push: assert property (acc && is_data && !host_rnw_i && word_done |=>
    wr_valid_o && wr_data_o == host_data_port)
    else $error("completed host word not offered to dma");
  a_rd_stall: assert property (ce_i && host_req_i && is_data && host_rnw_i
    && !rf_full_reg |-> !host_ready_o ##1 (rd_req_o || rf_full_reg))
    else $error("read served without a fetched word");
  a_rd_fill: assert property (ce_i && rd_req_o && rd_valid_i |=>
    rf_full_reg && rf_data_reg == $past(rd_data_i) && !rd_req_o)
    else $error("dma word not captured in read fifo");
  a_hw_order: assert property (acc && is_data && host_rnw_i && mux16_i
    && !host_second_i && !halfword_order_i
    |=> host_rdata_o[`HP_LO_MSB:`HP_LO_LSB] == $past(rf_data_reg[`HP_HI_MSB:`HP_HI_LSB]))
    else $error("first halfword not the upper half");
  a_half_pair: assert property (acc && is_data && host_rnw_i && mux16_i && !host_second_i
    |=> rf_full_reg)
    else $error("first halfword popped the read word");
  a_single_addr: assert property (acc && is_addr && !host_rnw_i && !dual_addr_i
    |=> read_address_reg == write_address_reg)
    else $error("single mode address registers differ");
  a_addr_hold: assert property (!(acc && is_addr && !host_rnw_i) |=>
    $stable(write_address_reg) && $stable(read_address_reg))
    else $error("address changed without host write");
  a_addr_back: assert property (acc && is_addr && !host_rnw_i && !mux16_i && !dual_addr_i
    ##1 (acc && is_addr && host_rnw_i && !mux16_i) |=> host_rdata_o == $past(host_wdata_i, 2))
    else $error("address read differs from last write");
  a_word_32: assert property (acc && is_data && !host_rnw_i && !mux16_i
    |=> host_data_port == $past(host_wdata_i))
    else $error("full word write not held in data register");

endmodule

// ==== sim/dma_model.sv ====
// dma side model: sink for written words, source for fetched words
// assumes design requests are levels held until the matching handshake
`timescale 1ns/1ps
module dma_model
  import host_port_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  slow_i,
  input  wire word_t word_i,
  input  wire logic  wr_valid_i,
  input  wire word_t wr_data_i,
  output logic       wr_ready_o,
  input  wire logic  rd_req_i,
  output logic       rd_valid_o,
  output word_t      rd_data_o,
  output word_t      taken_o
);
  logic [1:0] cnt_reg;
  logic       go;
  // slow mode stalls three cycles so the host sees refusals
  assign go = ~slow_i | (cnt_reg == 2'h3);
  initial begin
    cnt_reg = 2'h0;
    wr_ready_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_data_o = 32'h0;
    taken_o = 32'h0;
  end
  always @(posedge clk_i) begin
    cnt_reg <= (wr_valid_i | rd_req_i) ? cnt_reg + 2'h1 : 2'h0;
    wr_ready_o <= wr_valid_i & ~wr_ready_o & go;
    rd_valid_o <= rd_req_i & ~rd_valid_o & go;
    // idle data toggles so a stale word cannot pass for a fresh one
    rd_data_o <= (rd_req_i & ~rd_valid_o & go) ? word_i : ~rd_data_o;
    if (wr_valid_i & wr_ready_o) begin
      taken_o <= wr_data_i;
    end
  end
endmodule

// ==== sim/tb_host_port_data_address_regs.sv ====
// bench for the host data port and address registers
// assumes the dma model stands on the memory side
`timescale 1ns/1ps
module tb_host_port_data_address_regs;
  import host_port_pkg::*;
  `define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, s); end end
  logic  clk = 1'b0, rst_n = 1'b0, mux16 = 1'b0, order = 1'b0, dual = 1'b0, slow = 1'b0;
  logic  req = 1'b0, rnw = 1'b0, sel = 1'b0, asel = 1'b0, sec = 1'b0, ce = 1'b1;
  logic  ready, wvalid, wrdy, rreq, rvalid;
  word_t wdata = 32'h0, word = 32'h0, rdata, wdat, waddr, raddr, rdat, cra, cwa, taken, r;
  int    num_errors = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  host_port_data_address_regs dut_u (.sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
    .mux16_i(mux16), .halfword_order_i(order), .dual_addr_i(dual), .host_req_i(req),
    .host_rnw_i(rnw), .host_sel_i(sel), .host_addr_sel_i(asel), .host_second_i(sec),
    .host_wdata_i(wdata), .host_rdata_o(rdata), .host_ready_o(ready), .wr_valid_o(wvalid),
    .wr_data_o(wdat), .wr_addr_o(waddr), .wr_ready_i(wrdy), .rd_req_o(rreq),
    .rd_addr_o(raddr), .rd_valid_i(rvalid), .rd_data_i(rdat), .cpu_rd_addr_o(cra),
    .cpu_wr_addr_o(cwa));
  dma_model dma_u (.clk_i(clk), .slow_i(slow), .word_i(word), .wr_valid_i(wvalid),
    .wr_data_i(wdat), .wr_ready_o(wrdy), .rd_req_i(rreq), .rd_valid_o(rvalid),
    .rd_data_o(rdat), .taken_o(taken));
  task automatic xfer(input logic w_rnw, w_sel, w_asel, w_sec, input word_t wd);
    int n;
    n = 0;
    req <= 1'b1;
    rnw <= w_rnw;
    sel <= w_sel;
    asel <= w_asel;
    sec <= w_sec;
    wdata <= wd;
    do begin @(posedge clk); n++; end while (ready !== 1'b1 && n < 60);
    if (n >= 60) num_errors++;
    req <= 1'b0;
    @(posedge clk);
    r = rdata;
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (wvalid !== 1'b0 && n < 60) begin @(posedge clk); n++; end
    if (n >= 60) num_errors++;
  endtask
  task automatic t_reset();
    `CHK("data reset", 32'h0, rdata)
    `CHK("cpu views", 64'h0, {cra, cwa})
    xfer(1'b1, 1'b1, 1'b0, 1'b0, 32'h0);
    `CHK("addr reset", 32'h0, r)
  endtask
  task automatic t_word();
    slow <= 1'b1;
    xfer(1'b0, 1'b1, 1'b1, 1'b0, 32'h0000_0100);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 32'h1357_9bdf);
    `CHK("fifo word", {1'b1, 32'h1357_9bdf}, {wvalid, wdat})
    `CHK("wr addr", 32'h0000_0100, waddr)
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 32'h2468_ace0);
    drain();
    `CHK("dma took", 32'h2468_ace0, taken)
    word <= 32'hfeed_0042;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
    `CHK("read word", 32'hfeed_0042, r)
    `CHK("rd addr", 32'h0000_0100, raddr)
  endtask
  task automatic t_half(input logic o);
    mux16 <= 1'b1;
    order <= o;
    slow <= 1'b0;
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_1234);
    xfer(1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_abcd);
    drain();
    `CHK("half wr", o ? 32'habcd_1234 : 32'h1234_abcd, taken)
    word <= 32'h89ab_cdef;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
    `CHK("half rd 1", o ? 32'h0000_cdef : 32'h0000_89ab, r)
    xfer(1'b1, 1'b0, 1'b0, 1'b1, 32'h0);
    `CHK("half rd 2", o ? 32'h0000_89ab : 32'h0000_cdef, r)
  endtask
  task automatic t_addr();
    mux16 <= 1'b0;
    xfer(1'b0, 1'b1, 1'b1, 1'b0, 32'h0000_0200);
    `CHK("single", {2{32'h0000_0200}}, {cra, cwa})
    dual <= 1'b1;
    xfer(1'b0, 1'b1, 1'b1, 1'b0, 32'h0000_0300);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, 32'h0000_0280);
    `CHK("dual", {32'h0000_0280, 32'h0000_0300}, {cra, cwa})
    xfer(1'b1, 1'b1, 1'b0, 1'b0, 32'h0);
    `CHK("rd areg", 32'h0000_0280, r)
    xfer(1'b1, 1'b1, 1'b1, 1'b0, 32'h0);
    `CHK("wr areg", 32'h0000_0300, r)
  endtask
  // requests held while the enable is low must leave the read address and the fetch state alone
  task automatic t_freeze();
    ce <= 1'b0;
    req <= 1'b1;
    rnw <= 1'b0;
    sel <= 1'b1;
    asel <= 1'b0;
    wdata <= 32'h0000_0500;
    repeat (3) @(posedge clk);
    `CHK("frozen addr", 32'h0000_0280, cra)
    rnw <= 1'b1;
    sel <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("frozen fetch", 2'b00, {rreq, ready})
    ce <= 1'b1;
    req <= 1'b0;
    @(posedge clk);
  endtask
  // back-to-back address write and read, then halfword address assembly
  task automatic t_b2b();
    dual <= 1'b0;
    req <= 1'b1;
    rnw <= 1'b0;
    sel <= 1'b1;
    asel <= 1'b0;
    sec <= 1'b0;
    wdata <= 32'h0000_0640;
    @(posedge clk);
    rnw <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    `CHK("b2b addr", 32'h0000_0640, rdata)
    mux16 <= 1'b1;
    order <= 1'b0;
    xfer(1'b0, 1'b1, 1'b0, 1'b0, 32'h0000_0001);
    xfer(1'b0, 1'b1, 1'b0, 1'b1, 32'h0000_0a00);
    `CHK("half addr", {2{32'h0001_0a00}}, {cra, cwa})
    xfer(1'b1, 1'b1, 1'b0, 1'b0, 32'h0);
    `CHK("addr hi", 32'h0000_0001, r)
    xfer(1'b1, 1'b1, 1'b0, 1'b1, 32'h0);
    `CHK("addr lo", 32'h0000_0a00, r)
  endtask
  task automatic results();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_word();
    t_half(1'b0);
    t_half(1'b1);
    t_addr();
    t_freeze();
    t_b2b();
    results();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule
